/* File: hw/mbis_consts.vh */
// Constants for the memory and bus integrity supervisor.
// Included by the design files; definitions only.
`ifndef MBIS_CONSTS_VH
`define MBIS_CONSTS_VH

// CRC-32, reflected form of the standard polynomial
`define MBIS_CRC_POLY_REFL 32'hEDB88320
`define MBIS_CRC_INIT 32'hFFFFFFFF
`define MBIS_CRC_XOROUT 32'hFFFFFFFF

// Test patterns for the read/write memory sweep
`define MBIS_PAT_ZERO 1'h0
`define MBIS_PAT_ONE 1'h1

// Bus silence limit in clock cycles
`define MBIS_IDLE_LIMIT 16'h0400

// Inter-transceiver bus test message and wait limit
`define MBIS_XTEST_MSG 8'hA5
`define MBIS_XTEST_WAIT 8'hFF

`endif

/* File: hw/mbis_crc32_step.v */
// One byte step of reflected CRC-32.
// Pure combinational; caller holds the running register.
`timescale 1ns/10ps
`default_nettype none
`include "mbis_consts.vh"

module mbis_crc32_step (
  // Running value and new byte
  input wire [31:0] crc_in,
  input wire [7:0] data_in,
  // Updated value
  output reg [31:0] crc_out
);
  integer i;

  // Bitwise shift, LSB first
  always @* begin
    crc_out = crc_in ^ {24'h000000, data_in};
    for (i = 0; i < 8; i = i + 1) begin
      if (crc_out[0]) begin
        crc_out = (crc_out >> 1) ^ `MBIS_CRC_POLY_REFL;
      end else begin
        crc_out = crc_out >> 1;
      end
    end
  end
endmodule

`default_nettype wire

/* File: hw/mbis_top.v */
// Memory and bus integrity supervisor: boot test sequencer, RAM parity,
// NVM CRC-32 (boot, continuous, copy), bus supervision, X-bus test.
// Assumes one clock, memories answer reads one cycle after the request.
`timescale 1ns/10ps
`default_nettype none
`include "mbis_consts.vh"

module mbis_top #(
  parameter AW = 10,
  parameter DW = 8
) (
  // Clock, reset, enable
  input wire core_clk_in,
  input wire rst_in,
  input wire clk_en_in,
  // Boot control
  input wire restart_req_in,
  input wire odd_parity_sel_in,
  input wire [AW-1:0] ram_last_in,
  input wire [AW-1:0] nvm_used_last_in,
  input wire [31:0] nvm_ref_crc_in,
  input wire hw_check_ok_in,
  output reg app_start_ok_out,
  output reg boot_done_out,
  output reg boot_pass_out,
  output reg cpu_reset_out,
  // Test RAM port (sweep; one-cycle read)
  output reg ram_we_out,
  output reg [AW-1:0] ram_addr_out,
  output reg [DW-1:0] ram_wdata_out,
  input wire [DW-1:0] ram_rdata_in,
  // Operational RAM parity (word plus stored parity)
  input wire op_wr_in,
  input wire [DW-1:0] op_wdata_in,
  output reg op_wpar_out,
  input wire op_rd_valid_in,
  input wire [DW-1:0] op_rdata_in,
  input wire op_rpar_in,
  output reg parity_fault_out,
  // NVM / copy byte streams for CRC
  input wire nvm_byte_valid_in,
  input wire [7:0] nvm_byte_in,
  input wire nvm_end_in,
  input wire copy_byte_valid_in,
  input wire [7:0] copy_byte_in,
  input wire copy_end_in,
  output reg crc_fault_out,
  // Supervised bus (multi-unit only)
  input wire bus_active_in,
  input wire bus_tx_valid_in,
  input wire [7:0] bus_tx_data_in,
  input wire [7:0] bus_obs_in,
  input wire bus_rx_valid_in,
  input wire [7:0] bus_rx_data_in,
  input wire bus_rx_par_in,
  output reg bus_fault_out,
  // Inter-transceiver bus test
  input wire tx_enable_in,
  input wire dual_transmitter_combining_mode_in,
  output reg xbus_tx_valid_out,
  output reg [7:0] xbus_tx_data_out,
  input wire xbus_master_rx_valid_in,
  input wire [7:0] xbus_master_rx_in,
  input wire xbus_slave_rx_valid_in,
  input wire [7:0] xbus_slave_rx_in,
  output reg xtest_done_out,
  output reg xtest_pass_out,
  output reg combine_go_out
);
  // One-hot boot states
  localparam S_IDLE = 7'h01;
  localparam S_RWR = 7'h02;
  localparam S_RRD = 7'h04;
  localparam S_NVM = 7'h08;
  localparam S_HW = 7'h10;
  localparam S_DONE = 7'h20;
  localparam S_HALT = 7'h40;

  reg [6:0] state_reg;
  reg pat_reg;
  reg rd_pend_reg;
  reg odd_sel_reg;
  reg strap_taken_reg;
  reg [31:0] nvm_crc_reg;
  reg [AW-1:0] nvm_cnt_reg;
  reg nvm_skip_reg;
  reg [31:0] cont_crc_reg;
  reg [31:0] copy_crc_reg;
  reg [31:0] src_crc_reg;
  reg [15:0] idle_cnt_reg;
  reg bus_tx_prev_reg;
  reg [7:0] bus_tx_prev_data_reg;
  reg xt_busy_reg;
  reg xt_m_reg;
  reg xt_s_reg;
  reg xt_fail_reg;
  reg [7:0] xt_cnt_reg;
  reg xt_en_prev_reg;
  wire [31:0] nvm_crc_next;
  wire [31:0] copy_crc_next;
  wire [DW-1:0] pat_word;
  wire boot_nvm_byte;

  assign pat_word = {DW{pat_reg}};
  assign boot_nvm_byte = (state_reg == S_NVM) && nvm_byte_valid_in && !nvm_skip_reg;

  // Shared CRC step for NVM stream (boot and continuous use same feed)
  mbis_crc32_step u_nvm_crc (
    .crc_in(state_reg == S_NVM ? nvm_crc_reg : cont_crc_reg),
    .data_in(nvm_byte_in),
    .crc_out(nvm_crc_next)
  );

  // Copy destination stream
  mbis_crc32_step u_copy_crc (
    .crc_in(copy_crc_reg),
    .data_in(copy_byte_in),
    .crc_out(copy_crc_next)
  );

  // Parity sense strap caught after release, never under async reset
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      odd_sel_reg <= 1'h0;
      strap_taken_reg <= 1'h0;
    end else if (clk_en_in && !strap_taken_reg) begin
      odd_sel_reg <= odd_parity_sel_in;
      strap_taken_reg <= 1'h1;
    end
  end

  // Boot sequencer: RAM sweep, NVM CRC, hardware check, result
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= S_IDLE;
      pat_reg <= `MBIS_PAT_ZERO;
      rd_pend_reg <= 1'h0;
      nvm_crc_reg <= `MBIS_CRC_INIT;
      nvm_cnt_reg <= {AW{1'b0}};
      nvm_skip_reg <= 1'h0;
      ram_we_out <= 1'h0;
      ram_addr_out <= {AW{1'b0}};
      ram_wdata_out <= {DW{1'b0}};
      app_start_ok_out <= 1'h0;
      boot_done_out <= 1'h0;
      boot_pass_out <= 1'h0;
      cpu_reset_out <= 1'h0;
    end else if (clk_en_in) begin
      ram_we_out <= 1'h0;
      rd_pend_reg <= 1'h0;
      case (state_reg)
        S_IDLE: begin
          if (restart_req_in && strap_taken_reg) begin
            state_reg <= S_RWR;
            boot_pass_out <= 1'h0;
            app_start_ok_out <= 1'h0;
            boot_done_out <= 1'h0;
            pat_reg <= `MBIS_PAT_ZERO;
            ram_addr_out <= {AW{1'b0}};
          end
        end
        S_RWR: begin
          // Destructive fill with current pattern
          ram_we_out <= 1'h1;
          ram_wdata_out <= pat_word;
          if (ram_we_out && ram_addr_out == ram_last_in) begin
            ram_we_out <= 1'h0;
            ram_addr_out <= {AW{1'b0}};
            state_reg <= S_RRD;
          end else if (ram_we_out) begin
            ram_addr_out <= ram_addr_out + 1'b1;
          end
        end
        S_RRD: begin
          // Request, then compare on the following cycle
          rd_pend_reg <= !rd_pend_reg;
          if (rd_pend_reg) begin
            if (ram_rdata_in != pat_word) begin
              state_reg <= S_HALT;
              cpu_reset_out <= 1'h1;
            end else if (ram_addr_out == ram_last_in) begin
              ram_addr_out <= {AW{1'b0}};
              if (pat_reg == `MBIS_PAT_ZERO) begin
                pat_reg <= `MBIS_PAT_ONE;
                state_reg <= S_RWR;
              end else begin
                state_reg <= S_NVM;
                nvm_crc_reg <= `MBIS_CRC_INIT;
                nvm_cnt_reg <= {AW{1'b0}};
                nvm_skip_reg <= 1'h0;
              end
            end else begin
              ram_addr_out <= ram_addr_out + 1'b1;
            end
          end
        end
        S_NVM: begin
          // Bytes past the used range are preset filler, so they are skipped
          if (boot_nvm_byte) begin
            nvm_crc_reg <= nvm_crc_next;
            nvm_cnt_reg <= nvm_cnt_reg + 1'b1;
            nvm_skip_reg <= (nvm_cnt_reg == nvm_used_last_in);
          end
          if (nvm_end_in) begin
            if ((nvm_crc_reg ^ `MBIS_CRC_XOROUT) != nvm_ref_crc_in) begin
              state_reg <= S_DONE;
              boot_pass_out <= 1'h0;
              boot_done_out <= 1'h1;
            end else begin
              state_reg <= S_HW;
            end
          end
        end
        S_HW: begin
          // Single verdict from the non-disturbing hardware check
          state_reg <= S_DONE;
          boot_pass_out <= hw_check_ok_in;
          boot_done_out <= 1'h1;
          app_start_ok_out <= hw_check_ok_in;
        end
        S_DONE: begin
          if (restart_req_in) begin
            state_reg <= S_RWR;
            boot_pass_out <= 1'h0;
            app_start_ok_out <= 1'h0;
            boot_done_out <= 1'h0;
            pat_reg <= `MBIS_PAT_ZERO;
            ram_addr_out <= {AW{1'b0}};
          end
        end
        S_HALT: begin
          // Permanent stop; only reset leaves this state
          cpu_reset_out <= 1'h1;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Parity generate on write, check on read
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      op_wpar_out <= 1'h0;
      parity_fault_out <= 1'h0;
    end else if (clk_en_in) begin
      if (op_wr_in) begin
        op_wpar_out <= (^op_wdata_in) ^ odd_sel_reg;
      end
      parity_fault_out <= op_rd_valid_in &&
        (((^op_rdata_in) ^ op_rpar_in) != odd_sel_reg);
    end
  end

  // Continuous NVM and copy CRCs; fault pulse to the collector
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cont_crc_reg <= `MBIS_CRC_INIT;
      copy_crc_reg <= `MBIS_CRC_INIT;
      src_crc_reg <= `MBIS_CRC_INIT;
      crc_fault_out <= 1'h0;
    end else if (clk_en_in) begin
      crc_fault_out <= 1'h0;
      if (state_reg != S_NVM) begin
        if (nvm_byte_valid_in) begin
          cont_crc_reg <= nvm_crc_next;
        end
        if (nvm_end_in) begin
          // Final source value kept for copy comparison
          src_crc_reg <= cont_crc_reg ^ `MBIS_CRC_XOROUT;
          cont_crc_reg <= `MBIS_CRC_INIT;
          if ((cont_crc_reg ^ `MBIS_CRC_XOROUT) != nvm_ref_crc_in) begin
            crc_fault_out <= 1'h1;
          end
        end
      end
      if (copy_byte_valid_in) begin
        copy_crc_reg <= copy_crc_next;
      end
      if (copy_end_in) begin
        copy_crc_reg <= `MBIS_CRC_INIT;
        // Sets only, so a source fault in the same cycle is not lost
        if ((copy_crc_reg ^ `MBIS_CRC_XOROUT) != src_crc_reg) begin
          crc_fault_out <= 1'h1;
        end
      end
    end
  end

  // Bus supervision: echo compare, embedded parity, traffic presence.
  // Inputs connect only to shared multi-unit buses.
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      idle_cnt_reg <= 16'h0000;
      bus_tx_prev_reg <= 1'h0;
      bus_tx_prev_data_reg <= 8'h00;
      bus_fault_out <= 1'h0;
    end else if (clk_en_in) begin
      bus_tx_prev_reg <= bus_tx_valid_in;
      bus_tx_prev_data_reg <= bus_tx_data_in;
      if (!bus_active_in) begin
        idle_cnt_reg <= 16'h0000;
        bus_fault_out <= 1'h0;
      end else begin
        // Runs whenever bus functions run
        if (bus_rx_valid_in || bus_tx_valid_in) begin
          idle_cnt_reg <= 16'h0000;
        end else if (idle_cnt_reg != `MBIS_IDLE_LIMIT) begin
          idle_cnt_reg <= idle_cnt_reg + 16'h0001;
        end
        // One-cycle disturbance pulses; collector does filtering
        bus_fault_out <=
          (bus_tx_prev_reg && (bus_obs_in != bus_tx_prev_data_reg)) ||
          (bus_rx_valid_in && ((^bus_rx_data_in) != bus_rx_par_in)) ||
          (idle_cnt_reg == `MBIS_IDLE_LIMIT - 16'h0001);
      end
    end
  end

  // Inter-transceiver bus receiver test on combining-mode enable
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      xt_en_prev_reg <= 1'h0;
      xt_busy_reg <= 1'h0;
      xt_m_reg <= 1'h0;
      xt_s_reg <= 1'h0;
      xt_fail_reg <= 1'h0;
      xt_cnt_reg <= 8'h00;
      xbus_tx_valid_out <= 1'h0;
      xbus_tx_data_out <= 8'h00;
      xtest_done_out <= 1'h0;
      xtest_pass_out <= 1'h0;
      combine_go_out <= 1'h0;
    end else if (clk_en_in) begin
      xt_en_prev_reg <= tx_enable_in;
      xbus_tx_valid_out <= 1'h0;
      if (!tx_enable_in) begin
        combine_go_out <= 1'h0;
      end
      if (tx_enable_in && !xt_en_prev_reg && dual_transmitter_combining_mode_in
          && !xt_busy_reg) begin
        xt_busy_reg <= 1'h1;
        combine_go_out <= 1'h0;
        xtest_done_out <= 1'h0;
        xt_m_reg <= 1'h0;
        xt_s_reg <= 1'h0;
        xt_fail_reg <= 1'h0;
        xt_cnt_reg <= 8'h00;
        xbus_tx_valid_out <= 1'h1;
        xbus_tx_data_out <= `MBIS_XTEST_MSG;
      end else if (xt_busy_reg) begin
        xt_cnt_reg <= xt_cnt_reg + 8'h01;
        if (xbus_master_rx_valid_in) begin
          xt_m_reg <= xt_m_reg | (xbus_master_rx_in == `MBIS_XTEST_MSG);
        end
        if (xbus_slave_rx_valid_in) begin
          xt_s_reg <= xt_s_reg | (xbus_slave_rx_in == `MBIS_XTEST_MSG);
        end
        // One term per side, as both echoes may land in the same cycle
        xt_fail_reg <= xt_fail_reg |
          (xbus_master_rx_valid_in && (xbus_master_rx_in != `MBIS_XTEST_MSG)) |
          (xbus_slave_rx_valid_in && (xbus_slave_rx_in != `MBIS_XTEST_MSG));
        if ((xt_m_reg && xt_s_reg) || xt_fail_reg || xt_cnt_reg == `MBIS_XTEST_WAIT) begin
          xt_busy_reg <= 1'h0;
          xtest_done_out <= 1'h1;
          xtest_pass_out <= xt_m_reg && xt_s_reg && !xt_fail_reg;
          combine_go_out <= xt_m_reg && xt_s_reg && !xt_fail_reg && tx_enable_in;
        end
      end
    end
  end
endmodule

`default_nettype wire

/* File: verification/mbis_ram_model.sv */
// Test RAM behind the boot sweep port.
// Read data follows the address one cycle late, as the top expects.
`timescale 1ns/10ps
`default_nettype none
module mbis_ram_model #(
  parameter AW = 10,
  parameter DW = 8
) (
  input wire logic clk_in,
  input wire logic we_in,
  input wire logic flip_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wdata_in,
  output logic [DW-1:0] rdata_out
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Flip inverts bit 0 of every word read back, at any address
  always @(posedge clk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
    rdata_out <= mem[addr_in] ^ {{(DW-1){1'b0}}, flip_in};
  end
endmodule
`default_nettype wire

/* File: verification/mbis_top_asserts.sv */
// Port-level checker for the integrity supervisor top.
// Bound to each mbis_top; one clock, reset active high.
`timescale 1ns/10ps
`default_nettype none
module mbis_top_asserts #(
  parameter DW = 8
) (
  // Clock, reset and straps
  input wire logic core_clk_in, rst_in, clk_en_in, odd_parity_sel_in,
  // Operational parity
  input wire logic op_wr_in, op_rd_valid_in, op_rpar_in, op_wpar_out, parity_fault_out,
  input wire logic [DW-1:0] op_wdata_in, op_rdata_in,
  // Boot result and sweep port
  input wire logic app_start_ok_out, boot_done_out, boot_pass_out, cpu_reset_out,
  input wire logic ram_we_out,
  input wire logic [DW-1:0] ram_wdata_out,
  // Bus and X-bus test
  input wire logic bus_active_in, bus_fault_out, xbus_tx_valid_out, xtest_done_out,
  input wire logic xtest_pass_out, combine_go_out,
  input wire logic [7:0] xbus_tx_data_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  // Strap is static between resets, so its live value equals the captured one
  a_wpar_from_data: assert property (op_wr_in && clk_en_in |=>
    op_wpar_out == (^$past(op_wdata_in) ^ odd_parity_sel_in)) else $error("write parity wrong");
  a_rd_parity_fault: assert property (op_rd_valid_in && clk_en_in |=>
    parity_fault_out == (^{$past(op_rdata_in), $past(op_rpar_in)} ^ odd_parity_sel_in))
    else $error("read parity verdict wrong");
  a_no_read_quiet: assert property (!op_rd_valid_in && clk_en_in |=> !parity_fault_out)
    else $error("parity fault without a read");
  a_sweep_pattern: assert property (ram_we_out |->
    (ram_wdata_out == {DW{1'b0}} || ram_wdata_out == {DW{1'b1}})) else $error("sweep pattern");
  a_app_after_pass: assert property (app_start_ok_out |-> boot_done_out && boot_pass_out)
    else $error("application allowed without pass");
  a_halt_no_pass: assert property (cpu_reset_out |-> !boot_pass_out && !app_start_ok_out)
    else $error("pass shown after RAM failure");
  a_halt_sticky: assert property (cpu_reset_out |=> cpu_reset_out)
    else $error("processor reset dropped");
  a_combine_gate: assert property (combine_go_out |-> xtest_done_out && xtest_pass_out)
    else $error("combining started without passed test");
  a_xmsg_pulse: assert property (xbus_tx_valid_out |->
    xbus_tx_data_out == 8'hA5 ##1 !xbus_tx_valid_out) else $error("X-bus test message wrong");
  a_bus_idle_quiet: assert property (!bus_active_in [*3] |-> !bus_fault_out)
    else $error("bus fault while bus inactive");
endmodule

bind mbis_top mbis_top_asserts #(.DW(DW)) u_mbis_top_asserts (.core_clk_in, .rst_in,
  .clk_en_in, .odd_parity_sel_in, .op_wr_in, .op_rd_valid_in, .op_rpar_in, .op_wpar_out,
  .parity_fault_out, .op_wdata_in, .op_rdata_in, .app_start_ok_out, .boot_done_out,
  .boot_pass_out, .cpu_reset_out, .ram_we_out, .ram_wdata_out, .bus_active_in,
  .bus_fault_out, .xbus_tx_valid_out, .xtest_done_out, .xtest_pass_out, .combine_go_out,
  .xbus_tx_data_out);
`default_nettype wire

/* File: verification/mbis_top_test.sv */
// Self-checking bench for the integrity supervisor top.
// Bench drives every port; sweep RAM is mbis_ram_model.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module mbis_top_test;
  logic core_clk_in, rst_in, restart_req_in, odd_parity_sel_in, hw_check_ok_in, ram_flip;
  logic op_wr_in, op_rd_valid_in, op_rpar_in, nvm_byte_valid_in, nvm_end_in, copy_end_in;
  logic copy_byte_valid_in, bus_active_in, bus_tx_valid_in, bus_rx_valid_in, bus_rx_par_in;
  logic tx_enable_in, dual_transmitter_combining_mode_in, xbus_master_rx_valid_in;
  logic xbus_slave_rx_valid_in, app_start_ok_out, boot_done_out, boot_pass_out;
  logic cpu_reset_out, ram_we_out, op_wpar_out, parity_fault_out, crc_fault_out;
  logic bus_fault_out, xbus_tx_valid_out, xtest_done_out, xtest_pass_out, combine_go_out;
  logic [7:0] op_wdata_in, op_rdata_in, nvm_byte_in, copy_byte_in, bus_tx_data_in;
  logic [7:0] bus_obs_in, bus_rx_data_in, xbus_master_rx_in, xbus_slave_rx_in;
  logic [7:0] xbus_tx_data_out, ram_wdata_out, ram_rdata_in;
  logic [9:0] ram_addr_out;
  logic [31:0] nvm_ref_crc_in;
  int error_cnt = 0, n_checks = 0, cyc = 0, bf_cnt = 0, xt_cnt = 0;

  mbis_top u_mbis_top (.core_clk_in, .rst_in, .clk_en_in(1'b1), .restart_req_in,
    .odd_parity_sel_in, .ram_last_in(10'h00F), .nvm_used_last_in(10'h008), .nvm_ref_crc_in,
    .hw_check_ok_in, .app_start_ok_out, .boot_done_out, .boot_pass_out, .cpu_reset_out,
    .ram_we_out, .ram_addr_out, .ram_wdata_out, .ram_rdata_in, .op_wr_in, .op_wdata_in,
    .op_wpar_out, .op_rd_valid_in, .op_rdata_in, .op_rpar_in, .parity_fault_out,
    .nvm_byte_valid_in, .nvm_byte_in, .nvm_end_in, .copy_byte_valid_in, .copy_byte_in,
    .copy_end_in, .crc_fault_out, .bus_active_in, .bus_tx_valid_in, .bus_tx_data_in,
    .bus_obs_in, .bus_rx_valid_in, .bus_rx_data_in, .bus_rx_par_in, .bus_fault_out,
    .tx_enable_in, .dual_transmitter_combining_mode_in, .xbus_tx_valid_out, .xbus_tx_data_out,
    .xbus_master_rx_valid_in, .xbus_master_rx_in, .xbus_slave_rx_valid_in, .xbus_slave_rx_in,
    .xtest_done_out, .xtest_pass_out, .combine_go_out);
  mbis_ram_model u_mbis_ram_model (.clk_in(core_clk_in), .we_in(ram_we_out), .flip_in(ram_flip),
    .addr_in(ram_addr_out), .wdata_in(ram_wdata_out), .rdata_out(ram_rdata_in));

  // 125 MHz clock
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end

  // Pulse counters and hang limit; pulses are counted, not caught at one edge
  always @(posedge core_clk_in) begin
    cyc++;
    bf_cnt += bus_fault_out;
    xt_cnt += xbus_tx_valid_out;
    if (cyc == 6000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask

  task automatic stop_test;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic reset_dut(input logic odd);
    rst_in <= 1'b1;
    odd_parity_sel_in <= odd;
    ram_flip <= 1'b0;
    tick(5);
    rst_in <= 1'b0;
    tick(2);
  endtask

  // Write 0xB1 (four ones), read it back good then bad, back to back
  task automatic parity(input logic odd);
    tick(1);
    op_wr_in <= 1'b1;
    op_wdata_in <= 8'hB1;
    tick(1);
    op_wr_in <= 1'b0;
    op_rd_valid_in <= 1'b1;
    op_rdata_in <= 8'hB1;
    op_rpar_in <= odd;
    tick(1);
    `CHK(op_wpar_out, odd)
    op_rpar_in <= ~odd;
    tick(1);
    `CHK(parity_fault_out, 1'b0)
    op_rd_valid_in <= 1'b0;
    tick(1);
    `CHK(parity_fault_out, 1'b1)
  endtask

  // Nine bytes k, k+1, ... then the end pulse; returns once the verdict is out
  task automatic feed(input logic cp, input logic [7:0] k);
    for (int i = 0; i < 9; i++) begin
      nvm_byte_valid_in <= !cp;
      copy_byte_valid_in <= cp;
      nvm_byte_in <= k + i[7:0];
      copy_byte_in <= k + i[7:0];
      tick(1);
    end
    nvm_byte_valid_in <= 1'b0;
    copy_byte_valid_in <= 1'b0;
    nvm_end_in <= !cp;
    copy_end_in <= cp;
    tick(1);
    nvm_end_in <= 1'b0;
    copy_end_in <= 1'b0;
    tick(1);
  endtask

  // Full boot; image fed after the sweep, whose length is fixed by ram_last_in
  task automatic boot(input logic [31:0] crc, input logic hw, input logic pass);
    tick(1);
    nvm_ref_crc_in <= crc;
    hw_check_ok_in <= hw;
    restart_req_in <= 1'b1;
    tick(1);
    restart_req_in <= 1'b0;
    for (int w = 0; w < 5 && ram_we_out !== 1'b1; w++) tick(1);
    `CHK(ram_addr_out, 10'h000)
    `CHK(ram_wdata_out, 8'h00)
    `CHK(app_start_ok_out, 1'b0)
    tick(150);
    feed(1'b0, 8'h31);
    for (int w = 0; w < 20 && boot_done_out !== 1'b1; w++) tick(1);
    `CHK(boot_done_out, 1'b1)
    `CHK(boot_pass_out, pass)
    `CHK(app_start_ok_out, pass)
  endtask

  // RAM reads come back with bit 0 wrong; restarts must then be ignored
  task automatic halt_run;
    tick(1);
    ram_flip <= 1'b1;
    restart_req_in <= 1'b1;
    tick(1);
    restart_req_in <= 1'b0;
    for (int w = 0; w < 120 && cpu_reset_out !== 1'b1; w++) tick(1);
    `CHK(cpu_reset_out, 1'b1)
    restart_req_in <= 1'b1;
    tick(40);
    `CHK(ram_we_out, 1'b0)
    restart_req_in <= 1'b0;
  endtask

  // One driven word with echo error mask and one received word with parity bit
  task automatic bus_word(input logic [7:0] err, input logic par, input int exp);
    int b0;
    b0 = bf_cnt;
    tick(1);
    bus_tx_valid_in <= 1'b1;
    bus_tx_data_in <= 8'h5A;
    bus_obs_in <= 8'h5A ^ err;
    bus_rx_valid_in <= 1'b1;
    bus_rx_data_in <= 8'h3C;
    bus_rx_par_in <= par;
    tick(1);
    bus_tx_valid_in <= 1'b0;
    bus_rx_valid_in <= 1'b0;
    tick(1);
    bus_obs_in <= 8'h5A;
    tick(4);
    `CHK(bf_cnt - b0, exp)
  endtask

  // Done and message hold the last test's outcome until a new test starts
  task automatic xtest(input logic mode, input logic [7:0] sl, input logic pass);
    int x0;
    x0 = xt_cnt;
    tick(1);
    dual_transmitter_combining_mode_in <= mode;
    tx_enable_in <= 1'b1;
    tick(4);
    `CHK(xt_cnt - x0, int'(mode))
    `CHK(xbus_tx_data_out, 8'hA5)
    xbus_master_rx_valid_in <= 1'b1;
    xbus_slave_rx_valid_in <= 1'b1;
    xbus_master_rx_in <= 8'hA5;
    xbus_slave_rx_in <= sl;
    tick(1);
    xbus_master_rx_valid_in <= 1'b0;
    xbus_slave_rx_valid_in <= 1'b0;
    tick(4);
    `CHK(xtest_done_out, 1'b1)
    `CHK(xtest_pass_out, pass)
    `CHK(combine_go_out, pass)
    tx_enable_in <= 1'b0;
    tick(2);
  endtask

  // Main sequence
  initial begin
    rst_in = 1'b1;
    {restart_req_in, odd_parity_sel_in, hw_check_ok_in, ram_flip, op_wr_in, op_rd_valid_in,
      op_rpar_in, nvm_byte_valid_in, nvm_end_in, copy_end_in, copy_byte_valid_in,
      bus_active_in, bus_tx_valid_in, bus_rx_valid_in, bus_rx_par_in, tx_enable_in,
      dual_transmitter_combining_mode_in, xbus_master_rx_valid_in, xbus_slave_rx_valid_in,
      op_wdata_in, op_rdata_in, nvm_byte_in, copy_byte_in, bus_tx_data_in, bus_obs_in,
      bus_rx_data_in, xbus_master_rx_in, xbus_slave_rx_in, nvm_ref_crc_in} = '0;
    reset_dut(1'b0);
    parity(1'b0);
    boot(32'hCBF43926, 1'b1, 1'b1);
    feed(1'b0, 8'h31);
    `CHK(crc_fault_out, 1'b0)
    feed(1'b1, 8'h31);
    `CHK(crc_fault_out, 1'b0)
    feed(1'b0, 8'h32);
    `CHK(crc_fault_out, 1'b1)
    feed(1'b1, 8'h31);
    `CHK(crc_fault_out, 1'b1)
    boot(32'h00000000, 1'b1, 1'b0);
    boot(32'hCBF43926, 1'b0, 1'b0);
    bus_active_in <= 1'b1;
    bus_word(8'h00, 1'b0, 0);
    bus_word(8'h10, 1'b0, 1);
    bus_word(8'h00, 1'b1, 1);
    bus_word(8'h00, 1'b0, 1044 - 1044 + 1 - 1);
    tick(1044);
    `CHK(bf_cnt, 3)
    bus_active_in <= 1'b0;
    tick(1100);
    `CHK(bf_cnt, 3)
    bus_word(8'h10, 1'b1, 0);
    xtest(1'b1, 8'hA5, 1'b1);
    xtest(1'b1, 8'h5A, 1'b0);
    xtest(1'b0, 8'hA5, 1'b0);
    halt_run();
    reset_dut(1'b1);
    parity(1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
